// file: common/port_e_consts.vh
// Register offsets, field positions, reset values, the analog threshold and interrupt bits of the port block
`ifndef PORT_E_CONSTS_VH
`define PORT_E_CONSTS_VH
`define OFS_DIR_STATUS    4'h0
`define OFS_PIN_VALUE     4'h4
`define OFS_OUT_LATCH     4'h8
`define OFS_ANALOG_CFG    4'hc
`define OFS_IRQ_STATUS    5'h10
`define OFS_IRQ_MASK      5'h14
`define OFS_SLAVE_DATA_IN 5'h18
`define BIT_IN_PEND       7
`define BIT_OUT_PEND      6
`define BIT_IN_OVR        5
`define BIT_SLAVE_SEL     4
`define RST_DIR_STATUS    8'h07
`define RST_ANALOG_CFG    8'h00
`define ANALOG_DIGITAL_MIN 4'ha
`define IRQ_WRITE_END     0
`define IRQ_READ_END      1
`define IRQ_OVERRUN       2
`endif

// file: src/sync_pin.v
// Two-stage synchroniser for one pin input
`timescale 1ns/1ps
module sync_pin (
  clock,
  rst,
  din,
  dout
);
  input  wire clock;
  input  wire rst;
  input  wire din;
  output reg  dout;
  reg stage1;
  always @(posedge clock) begin
    if (rst) begin
      stage1 <= 1'b1;
      dout   <= 1'b1;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule // sync_pin

// file: src/pin_cell.v
// One bidirectional low pin: drive, digital input and analog gating
`timescale 1ns/1ps
module pin_cell (
  clock,
  rst,
  direction,
  latch_bit,
  analog_sel,
  pin_in,
  pin_out,
  pin_oe,
  digital_value,
  raw_value
);
  input  wire clock;
  input  wire rst;
  input  wire direction;
  input  wire latch_bit;
  input  wire analog_sel;
  input  wire pin_in;
  output wire pin_out;
  output wire pin_oe;
  output wire digital_value;
  output wire raw_value;
  // Driven value follows the latch whatever the analog setting
  assign pin_out = latch_bit;
  assign pin_oe  = ~direction;
  sync_pin u_sync (
    .clock (clock),
    .rst   (rst),
    .din   (pin_in),
    .dout  (raw_value)
  );
  // Analog selection blanks the digital path to zero
  assign digital_value = direction & ~analog_sel & raw_value;
endmodule // pin_cell

// file: src/port_e_block.v
// Three-pin port with top input pin, slave port control and status over Wishbone
// Operation
// - On the small package only the top input bit exists and only while master clear is disabled.
// - A low pin with direction 0 is driven from its latch bit, regardless of analog selection.
// - A low pin with direction 1 is sampled as a digital input, reading 0 while analog is selected.
// - After reset the three low pins are analog inputs for converter channels 5, 6 and 7.
// - With slave port mode and direction 1, pin 0 is the active-low read strobe.
// - With slave port mode and direction 1, pin 1 is the active-low write strobe.
// - With slave port mode, pin 2 is the active-low chip select.
// - With master clear enabled, the top pin is the external master clear input.
// - With master clear disabled, the top pin reads at bit 3 of the value register, else bit 3 is 0.
// - The top pin has no direction or latch bit and is never driven.
// - The low pins and their bits exist only on the large package; the top pin on all. On the small package the direction bits 2..0 still read 1.
// - Unimplemented bits read as 0: value 7..4, latch 7..3, direction bit 3.
// - Slave port mode bit 4 enables the slave port; clear leaves general-purpose pins.
// - Input word pending is set when an external write to the slave port ends.
// - Output word pending is cleared when the external master reads the slave data.
//
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "port_e_consts.vh"
module port_e_block #(
  parameter LARGE_PACKAGE = 1
) (
  clock,
  rst,
  wb_cyc_i,
  wb_stb_i,
  wb_we_i,
  wb_adr_i,
  wb_dat_i,
  wb_sel_i,
  wb_dat_o,
  wb_ack_o,
  master_clear_enable_cfg,
  pin_in,
  pin_out,
  pin_oe,
  port_top_input_pin,
  master_clear_n,
  analog_channel_enable,
  slave_bus_in,
  slave_bus_out,
  slave_bus_oe,
  out_word_load,
  out_word,
  irq
);
  input  wire        clock;
  input  wire        rst;
  input  wire        wb_cyc_i;
  input  wire        wb_stb_i;
  input  wire        wb_we_i;
  input  wire [7:0]  wb_adr_i;
  input  wire [31:0] wb_dat_i;
  input  wire [3:0]  wb_sel_i;
  output reg  [31:0] wb_dat_o;
  output reg         wb_ack_o;
  input  wire        master_clear_enable_cfg;
  input  wire [2:0]  pin_in;
  output wire [2:0]  pin_out;
  output wire [2:0]  pin_oe;
  input  wire        port_top_input_pin;
  output reg         master_clear_n;
  output wire [2:0]  analog_channel_enable;
  input  wire [7:0]  slave_bus_in;
  output reg  [7:0]  slave_bus_out;
  output wire        slave_bus_oe;
  input  wire        out_word_load;
  input  wire [7:0]  out_word;
  output wire        irq;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [2:0] pin_direction;
  reg  [2:0] out_latch;
  reg        slave_port_select;
  reg        input_word_pending;
  reg        output_word_pending;
  reg        input_overrun;
  reg  [7:0] analog_cfg;
  reg  [7:0] slave_data_in;
  reg  [2:0] irq_status;
  reg  [2:0] irq_mask;
  reg        top_sync1;
  reg        top_value;
  reg        write_active;
  reg        read_active;
  wire [2:0] digital_value;
  wire [2:0] raw_value;
  wire       analog_sel_any;
  wire       low_present;
  wire       top_present;
  wire       bus_req;
  wire       bus_wr;
  wire       bus_rd;
  wire       strobe_rd_low;
  wire       strobe_wr_low;
  wire       chip_sel_low;
  wire       ext_write;
  wire       ext_read;
  wire       write_end;
  wire       read_end;
  wire [2:0] irq_event;
  reg  [7:0] read_mux;
  wire       hit_dir;
  wire       hit_latch;
  wire       hit_analog;
  wire       hit_irq_status;
  wire       hit_irq_mask;
  wire       hit_data_in;
  localparam [7:0] DIR_RESET = `RST_DIR_STATUS;

  assign low_present = (LARGE_PACKAGE != 0);
  assign top_present = ~master_clear_enable_cfg;

  ////////////////////////////////////////////////////////////////////////////
  // Low pins
  // Configuration values below the threshold keep the pins analog
  assign analog_sel_any = (analog_cfg[3:0] < `ANALOG_DIGITAL_MIN);
  assign analog_channel_enable = low_present ? {3{analog_sel_any}} : 3'h0;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
      pin_cell u_cell (
        .clock         (clock),
        .rst           (rst),
        .direction     (pin_direction[gi] | ~low_present),
        .latch_bit     (out_latch[gi]),
        .analog_sel    (analog_sel_any),
        .pin_in        (pin_in[gi]),
        .pin_out       (pin_out[gi]),
        .pin_oe        (pin_oe[gi]),
        .digital_value (digital_value[gi]),
        .raw_value     (raw_value[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Top pin, never driven
  always @(posedge clock) begin
    if (rst) begin
      top_sync1      <= 1'b1;
      top_value      <= 1'b1;
      master_clear_n <= 1'b1;
    end else begin
      top_sync1      <= port_top_input_pin;
      top_value      <= top_sync1;
      master_clear_n <= master_clear_enable_cfg ? top_value : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slave port strobes
  assign strobe_rd_low = slave_port_select & pin_direction[0] & ~raw_value[0];
  assign strobe_wr_low = slave_port_select & pin_direction[1] & ~raw_value[1];
  assign chip_sel_low  = slave_port_select & low_present & ~raw_value[2];
  assign ext_write = chip_sel_low & strobe_wr_low;
  assign ext_read  = chip_sel_low & strobe_rd_low;
  assign write_end = write_active & ~ext_write;
  assign read_end  = read_active & ~ext_read;
  assign slave_bus_oe = read_active;
  assign irq_event = {write_end & input_word_pending, read_end, write_end};

  always @(posedge clock) begin
    if (rst) begin
      write_active  <= 1'b0;
      read_active   <= 1'b0;
    end else begin
      write_active <= ext_write;
      read_active  <= ext_read;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data words: last byte seen during a write, and the word offered to reads
  always @(posedge clock) begin
    if (rst) begin
      slave_data_in <= 8'h00;
      slave_bus_out <= 8'h00;
    end else begin
      if (ext_write) begin
        slave_data_in <= slave_bus_in;
      end
      if (out_word_load) begin
        slave_bus_out <= out_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
  assign bus_rd  = bus_req & ~wb_we_i;
  // One decode per register, shared by the write and clear paths
  assign hit_dir        = (wb_adr_i == {4'h0, `OFS_DIR_STATUS});
  assign hit_latch      = (wb_adr_i == {4'h0, `OFS_OUT_LATCH});
  assign hit_analog     = (wb_adr_i == {4'h0, `OFS_ANALOG_CFG});
  assign hit_irq_status = (wb_adr_i == {3'h0, `OFS_IRQ_STATUS});
  assign hit_irq_mask   = (wb_adr_i == {3'h0, `OFS_IRQ_MASK});
  assign hit_data_in    = (wb_adr_i == {3'h0, `OFS_SLAVE_DATA_IN});

  always @* begin
    read_mux = 8'h00;
    case (wb_adr_i)
      {4'h0, `OFS_DIR_STATUS}: read_mux = {input_word_pending, output_word_pending, input_overrun,
                                           slave_port_select, 1'b0, pin_direction};
      {4'h0, `OFS_PIN_VALUE}:  read_mux = {4'h0, top_present & top_value,
                                           low_present ? digital_value : 3'h0};
      {4'h0, `OFS_OUT_LATCH}:  read_mux = {5'h00, out_latch};
      {4'h0, `OFS_ANALOG_CFG}: read_mux = analog_cfg;
      {3'h0, `OFS_IRQ_STATUS}: read_mux = {5'h00, irq_status};
      {3'h0, `OFS_IRQ_MASK}:   read_mux = {5'h00, irq_mask};
      {3'h0, `OFS_SLAVE_DATA_IN}: read_mux = slave_data_in;
      default:                 read_mux = 8'h00;
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_rd ? {24'h000000, read_mux} : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bits
  always @(posedge clock) begin
    if (rst) begin
      pin_direction       <= DIR_RESET[2:0];
      slave_port_select   <= 1'b0;
      out_latch           <= 3'h0;
      analog_cfg          <= `RST_ANALOG_CFG;
      irq_mask            <= 3'h0;
    end else begin
      if (bus_wr && hit_dir) begin
        if (low_present) begin
          pin_direction <= wb_dat_i[2:0];
        end
        slave_port_select <= wb_dat_i[`BIT_SLAVE_SEL] & low_present;
      end
      if (bus_wr && hit_latch && low_present) begin
        out_latch <= wb_dat_i[2:0];
      end
      if (bus_wr && hit_analog) begin
        analog_cfg <= wb_dat_i[7:0];
      end
      if (bus_wr && hit_irq_mask) begin
        irq_mask <= wb_dat_i[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slave port status flags, set wins over software clear
  always @(posedge clock) begin
    if (rst) begin
      input_word_pending  <= 1'b0;
      output_word_pending <= 1'b0;
      input_overrun       <= 1'b0;
    end else begin
      // Writing zero to the overrun bit clears it
      if (bus_wr && hit_dir && !wb_dat_i[`BIT_IN_OVR]) begin
        input_overrun <= 1'b0;
      end
      // Reading the input word consumes it
      if (bus_rd && hit_data_in) begin
        input_word_pending <= 1'b0;
      end
      if (out_word_load) begin
        output_word_pending <= 1'b1;
      end
      if (ext_read) begin
        output_word_pending <= 1'b0;
      end
      if (write_end) begin
        input_word_pending <= 1'b1;
        if (input_word_pending) begin
          input_overrun <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear, set wins
  always @(posedge clock) begin
    if (rst) begin
      irq_status <= 3'h0;
    end else begin
      if (bus_wr && hit_irq_status) begin
        irq_status <= (irq_status & ~wb_dat_i[2:0]) | irq_event;
      end else begin
        irq_status <= irq_status | irq_event;
      end
    end
  end

  assign irq = |(irq_status & irq_mask);
endmodule // port_e_block

// file: dv/port_e_assertions.sv
// Checker on the port block's bus and pin ports
`timescale 1ns/1ps
module port_e_assertions (
  input wire        clock,
  input wire        rst,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        master_clear_enable_cfg,
  input wire [2:0]  pin_in,
  input wire [2:0]  pin_out,
  input wire [2:0]  pin_oe,
  input wire        master_clear_n,
  input wire [2:0]  analog_channel_enable,
  input wire        slave_bus_oe,
  input wire        irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire wr = wb_ack_o && wb_we_i && wb_sel_i[0];
  wire rd = wb_ack_o && !wb_we_i;
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_latch; wr && wb_adr_i == 8'h08 |-> pin_out == wb_dat_i[2:0]; endproperty
  a_latch: assert property (p_latch) else $error("pin drive differs from latch");
  property p_dir; wr && wb_adr_i == 8'h00 |-> pin_oe == ~wb_dat_i[2:0]; endproperty
  a_dir: assert property (p_dir) else $error("pin enable differs from direction");
  property p_rst; $past(rst) |-> analog_channel_enable == 3'h7 && pin_oe == 3'h0; endproperty
  a_rst: assert property (p_rst) else $error("pins not analog inputs after reset");
  property p_unimpl;
    rd |-> (wb_adr_i != 8'h04 || wb_dat_o[7:4] == 4'h0) && (wb_adr_i != 8'h08 || wb_dat_o[7:3] == 5'h0)
      && (wb_adr_i != 8'h00 || !wb_dat_o[3]);
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unused bit reads as one");
  property p_top_off; rd && wb_adr_i == 8'h04 && master_clear_enable_cfg |-> !wb_dat_o[3]; endproperty
  a_top_off: assert property (p_top_off) else $error("top bit readable in clear mode");
  property p_master_clear_input_off; !master_clear_enable_cfg [*5] |-> master_clear_n; endproperty
  a_master_clear_input_off: assert property (p_master_clear_input_off) else $error("clear request while disabled");
  property p_strobe; $rose(slave_bus_oe) |-> pin_oe == 3'h0 && !pin_in[0] && !pin_in[2]; endproperty
  a_strobe: assert property (p_strobe) else $error("read drive without strobes");
  c_read: cover property (slave_bus_oe);
  c_irq: cover property (irq);
  c_master_clear_input: cover property (!master_clear_n);
endmodule // port_e_assertions
bind port_e_block port_e_assertions port_e_assertions_i (.*);

// file: dv/ext_host.sv
// Far-side host: pin levels, strobes and data bus of the slave port
`timescale 1ns/1ps
module ext_host (
  input  wire       clock,
  input  wire [2:0] pin_out,
  input  wire [2:0] pin_oe,
  output wire [2:0] pin_in,
  output reg  [7:0] slave_bus_in,
  input  wire [7:0] slave_bus_out
);
  reg [2:0] drv = 3'h7;
  // A wire shows the device level while it drives, else ours
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
  initial slave_bus_in = 8'h00;
  task level(input [2:0] v);
    begin
      @(posedge clock);
      drv <= v;
    end
  endtask
  task write_word(input [7:0] d);
    begin
      @(posedge clock);
      slave_bus_in <= d;
      drv <= 3'h1;
      repeat (6) @(posedge clock);
      drv <= 3'h7;
      repeat (4) @(posedge clock);
      slave_bus_in <= ~d;
      repeat (6) @(posedge clock);
    end
  endtask
  task read_word(output [7:0] d);
    begin
      @(posedge clock);
      drv <= 3'h2;
      repeat (6) @(posedge clock);
      d = slave_bus_out;
      drv <= 3'h7;
      repeat (8) @(posedge clock);
    end
  endtask
endmodule // ext_host

// file: dv/tb_top.sv
// Self-checking bench for the port block
`timescale 1ns/1ps
module tb_top;
  reg         clock = 1'b0;
  reg         rst = 1'b1;
  reg         cyc = 1'b0;
  reg         stb = 1'b0;
  reg         we = 1'b0;
  reg  [7:0]  adr = 8'h00;
  reg  [31:0] wdat = 32'h0;
  reg  [3:0]  sel = 4'h0;
  reg  [3:0]  bsel = 4'h1;
  reg         mcfg = 1'b0;
  reg         top = 1'b1;
  reg         load = 1'b0;
  reg  [7:0]  oword = 8'h00;
  reg  [31:0] r;
  reg  [7:0]  x;
  wire [31:0] rdat;
  wire        ack, master_clear_input_n, boe, irq;
  wire [2:0]  pin_in, pin_out, pin_oe, ana;
  wire [7:0]  bin, bout;
  integer     err_total = 0;
  integer     comparisons = 0;
  always #25 clock = ~clock;
  port_e_block port_e_block_i (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .master_clear_enable_cfg(mcfg), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .port_top_input_pin(top), .master_clear_n(master_clear_input_n), .analog_channel_enable(ana), .slave_bus_in(bin),
    .slave_bus_out(bout), .slave_bus_oe(boe), .out_word_load(load), .out_word(oword), .irq(irq));
  ext_host ext_i (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
    .slave_bus_in(bin), .slave_bus_out(bout));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clock);
      {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, bsel};
      @(posedge clock);
      while (ack !== 1'b1) @(posedge clock);
      r = rdat;
      {cyc, stb} <= 2'b00;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(r, e);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task t_gpio;
    begin
      rd(8'h00, 32'h07);
      rd(8'h0c, 32'h00);
      chk({ana, pin_oe, irq}, 7'h70);
      bus(1'b1, 8'h0c, 32'h0a);
      bus(1'b1, 8'h08, 32'hff);
      rd(8'h08, 32'h07);
      bsel <= 4'he;
      bus(1'b1, 8'h08, 32'h00);
      bsel <= 4'h1;
      rd(8'h08, 32'h07);
      bus(1'b1, 8'h00, 32'h0a);
      rd(8'h00, 32'h02);
      bus(1'b1, 8'h0c, 32'h00);
      chk({pin_oe, pin_out}, 6'h2f);
      bus(1'b1, 8'h00, 32'h07);
      ext_i.level(3'h3);
      bus(1'b1, 8'h0c, 32'h0a);
      rd(8'h04, 32'h0b);
      bus(1'b1, 8'h0c, 32'h00);
      rd(8'h04, 32'h08);
      rd(8'h40, 32'h00);
      ext_i.level(3'h7);
      $display("gpio test done");
    end
  endtask
  task t_slave;
    begin
      bus(1'b1, 8'h0c, 32'h0a);
      bus(1'b1, 8'h14, 32'h00);
      bus(1'b1, 8'h00, 32'h17);
      ext_i.write_word(8'h5a);
      rd(8'h00, 32'h97);
      chk(irq, 1'b0);
      bus(1'b1, 8'h14, 32'h07);
      chk(irq, 1'b1);
      rd(8'h18, 32'h5a);
      ext_i.write_word(8'h11);
      ext_i.write_word(8'h22);
      rd(8'h00, 32'hb7);
      bus(1'b1, 8'h00, 32'h17);
      bus(1'b0, 8'h18, 32'h0);
      rd(8'h00, 32'h17);
      @(posedge clock);
      {load, oword} <= 9'h1c3;
      @(posedge clock);
      load <= 1'b0;
      rd(8'h00, 32'h57);
      ext_i.read_word(x);
      chk(x, 8'hc3);
      rd(8'h00, 32'h17);
      rd(8'h10, 32'h07);
      rd(8'h14, 32'h07);
      bus(1'b1, 8'h10, 32'h07);
      rd(8'h10, 32'h00);
      chk(irq, 1'b0);
      bus(1'b1, 8'h00, 32'h07);
      ext_i.write_word(8'h33);
      rd(8'h00, 32'h07);
      $display("slave test done");
    end
  endtask
  task t_master_clear_input;
    begin
      mcfg <= 1'b1;
      top <= 1'b0;
      repeat (6) @(posedge clock);
      chk(master_clear_input_n, 1'b0);
      top <= 1'b1;
      repeat (6) @(posedge clock);
      chk(master_clear_input_n, 1'b1);
      rd(8'h04, 32'h07);
      mcfg <= 1'b0;
      $display("clear test done");
    end
  endtask
  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    err_total = err_total + 1;
    conclude;
  end
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_gpio;
    t_slave;
    t_master_clear_input;
    conclude;
  end
endmodule // tb_top
